// file: rtl/etp_regs.svh
/*
  Register offsets, field positions and reset values for the external,
  timer and port-change interrupt source block.
  Assumes an 8-bit register port with one-cycle read latency.
*/
`ifndef ETP_REGS_SVH
`define ETP_REGS_SVH

// Register offsets (word index on the plain register port)
`define ETP_OFF_RCAUSE     4'h0
`define ETP_OFF_CTRL_A     4'h1
`define ETP_OFF_CTRL_B     4'h2
`define ETP_OFF_CTRL_C     4'h3
`define ETP_OFF_EXT_FLAG   4'h4
`define ETP_OFF_EXT_EN     4'h5
`define ETP_OFF_IRQ_STAT   4'h6
`define ETP_OFF_IRQ_CLR    4'h7
`define ETP_OFF_IRQ_EN     4'h8
`define ETP_OFF_TMR_LO     4'h9
`define ETP_OFF_TMR_HI     4'hA
`define ETP_OFF_TMR_CFG    4'hB

// Reset-cause register fields
`define ETP_RC_PRIO_EN     7
`define ETP_RC_UNUSED      6
`define ETP_RC_CFG_MISM    5
`define ETP_RC_SOFT_RST    4
`define ETP_RC_WDT_TO      3
`define ETP_RC_PWR_DOWN    2
`define ETP_RC_POR         1
`define ETP_RC_BOR         0
`define ETP_RC_RESET       8'h3C
`define ETP_RC_SW_MASK     8'hB3

// Control register A fields
`define ETP_A_GIE          7
`define ETP_A_TMR_EN       5
`define ETP_A_PCH_EN       3
`define ETP_A_TMR_FLAG     2
`define ETP_A_PCH_FLAG     0
// Control register B fields
`define ETP_B_EDGE_LSB     4
`define ETP_B_TMR_PRIO     2
`define ETP_B_EXT3_PRIO    1
`define ETP_B_PCH_PRIO     0
// Control register C fields
`define ETP_C_EXT2_PRIO    7
`define ETP_C_EXT1_PRIO    6

`define ETP_ZERO8          8'h00
`define ETP_B_RESET        8'hF7
`define ETP_C_RESET        8'hC0

`endif

// file: rtl/etp_pkg.sv
/*
  Types for the interrupt source block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package etp_pkg;
  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } etp_bus_t;

  // Wake and vector control towards the core
  typedef struct packed {
    logic irq_high;
    logic irq_low;
    logic wake;
    logic vector;
    logic resume;
  } etp_core_t;

  // Context to be saved on interrupt entry
  typedef struct packed {
    logic [20:0] ret_pc;
    logic [7:0]  acc;
    logic [7:0]  status;
    logic [3:0]  bank;
  } etp_ctx_t;

  typedef enum logic [1:0] {
    ETP_RUN,
    ETP_SLEEP,
    ETP_ENTRY
  } etp_state_t;
endpackage

// file: rtl/etp_irq_sources.sv
/*
  External line, timer-zero overflow and port-change interrupt sources,
  priority steering, wake logic, context shadow and reset-cause register.
  Assumes pins already synchronous to clk_in and a core that acknowledges
  interrupt entry with a one-cycle pulse.
*/
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "etp_regs.svh"

// Functional notes
// - Priority enable set gives separate high and low interrupt levels.
// - Priority enable clear gives one level, priorities ignored.
// - Per-source priority bits act only while priority enable is set.
// - Reset-cause register records cause of last reset or wake-up.
// - Bit 6 of reset-cause register always reads zero.
// - Edge select one means rising edge, zero means falling edge.
// - Selected edge sets line flag; enable clear blocks its core request and wake, not irq_out.
// - Enabled external line wakes core if enabled before sleeping.
// - After wake, vector if global enable set, otherwise resume.
// - Line 1,2 priority in control C bits 6,7; line 3 in B bit 1.
// - Line zero has no priority bit and is always high priority.
// - Eight-bit mode sets overflow flag on FF to 00 rollover.
// - Sixteen-bit mode sets flag only on FFFF to 0000 rollover.
// - Timer enable is A bit 5; timer priority is B bit 2.
// - Change on upper port nibble sets A bit 0; enable A3, prio B0.
// - Entry pushes return PC and shadows accumulator, status, bank.
module etp_irq_sources
  import etp_pkg::*;
#(
  parameter int EXT_LINES = 4
) (
  input  wire logic            clk_in,
  input  wire logic            reset_n_in,
  input  wire etp_bus_t        bus_in,
  output logic [7:0]           rdata_out,
  input  wire logic [EXT_LINES-1:0] ext_pins_in,
  input  wire logic [7:4]      port_pins_in,
  input  wire logic            tmr_tick_in,
  input  wire logic            sleep_req_in,
  input  wire logic            entry_ack_in,
  input  wire etp_ctx_t        ctx_in,
  input  wire logic [5:0]      cause_set_in,
  output etp_core_t            core_out,
  output etp_ctx_t             shadow_out,
  output logic [20:0]          stack_top_out,
  output logic [4:0]           stack_ptr_out,
  output logic                 irq_out
);

  logic [7:0] rcause_reg;
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] ctrl_c_reg;
  logic [EXT_LINES-1:0] ext_flag_reg;
  logic [EXT_LINES-1:0] ext_en_reg;
  logic [EXT_LINES-1:0] ext_prev_reg;
  logic [7:4] port_prev_reg;
  logic [15:0] tmr_reg;
  logic        tmr_16bit_reg;
  logic [2:0]  stat_reg;
  logic [2:0]  stat_en_reg;
  logic [EXT_LINES-1:0] wake_arm_reg;
  etp_state_t  state_reg;
  logic [20:0] stack_mem [0:31];
  logic [4:0]  sp_reg;
  etp_ctx_t    shadow_reg;

  logic [EXT_LINES-1:0] ext_edge;
  logic [EXT_LINES-1:0] ext_prio;
  logic        port_change;
  logic        tmr_wrap;
  logic        wr_a;
  logic        wr_ext_flag;
  logic        any_high;
  logic        any_low;
  logic        prio_en;
  logic [2:0]  stat_evt;

  assign wr_a        = bus_in.wr && bus_in.addr == `ETP_OFF_CTRL_A;
  assign wr_ext_flag = bus_in.wr && bus_in.addr == `ETP_OFF_EXT_FLAG;
  assign prio_en     = rcause_reg[`ETP_RC_PRIO_EN];

  ////////////////////////////////////////////////////////////////////////
  // External lines: edge detect, flags, priority map
  generate
    for (genvar i = 0; i < EXT_LINES; i++) begin : g_ext
      // Edge select bit per line lives in control B upper bits
      assign ext_edge[i] = ctrl_b_reg[`ETP_B_EDGE_LSB + i]
        ? (ext_pins_in[i] && !ext_prev_reg[i])
        : (!ext_pins_in[i] && ext_prev_reg[i]);
      // Hardware set beats a same-cycle software clear
      always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
          ext_flag_reg[i] <= 1'b0;
        end else if (ext_edge[i]) begin
          ext_flag_reg[i] <= 1'b1;
        end else if (wr_ext_flag) begin
          ext_flag_reg[i] <= bus_in.wdata[i];
        end
      end
    end
  endgenerate

  // Line zero is hard-wired high priority
  assign ext_prio[0] = 1'b1;
  assign ext_prio[1] = ctrl_c_reg[`ETP_C_EXT1_PRIO];
  assign ext_prio[2] = ctrl_c_reg[`ETP_C_EXT2_PRIO];
  assign ext_prio[3] = ctrl_b_reg[`ETP_B_EXT3_PRIO];

  // Previous samples track the pins through reset: no false edge after it
  always_ff @(posedge clk_in) begin
    ext_prev_reg  <= ext_pins_in;
    port_prev_reg <= port_pins_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer zero count, 8- or 16-bit rollover
  // Low byte wraps in both modes; only the pair wrap counts in 16-bit
  assign tmr_wrap = tmr_tick_in && (tmr_16bit_reg
    ? (tmr_reg == 16'hFFFF)
    : (tmr_reg[7:0] == 8'hFF));

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tmr_reg       <= 16'h0000;
      tmr_16bit_reg <= 1'b0;
    end else if (bus_in.wr && bus_in.addr == `ETP_OFF_TMR_LO) begin
      tmr_reg[7:0] <= bus_in.wdata;
    end else if (bus_in.wr && bus_in.addr == `ETP_OFF_TMR_HI) begin
      tmr_reg[15:8] <= bus_in.wdata;
    end else if (bus_in.wr && bus_in.addr == `ETP_OFF_TMR_CFG) begin
      tmr_16bit_reg <= bus_in.wdata[0];
    end else if (tmr_tick_in) begin
      tmr_reg <= tmr_16bit_reg ? tmr_reg + 16'h0001
                               : {8'h00, tmr_reg[7:0] + 8'h01};
    end
  end

  assign port_change = port_pins_in != port_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Control A: enables and sticky source flags
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_a_reg <= `ETP_ZERO8;
    end else begin
      if (wr_a) begin
        ctrl_a_reg <= bus_in.wdata;
      end
      if (tmr_wrap) begin
        ctrl_a_reg[`ETP_A_TMR_FLAG] <= 1'b1;
      end
      if (port_change) begin
        ctrl_a_reg[`ETP_A_PCH_FLAG] <= 1'b1;
      end
    end
  end

  // Control B, C and line enables
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_b_reg <= `ETP_B_RESET;
      ctrl_c_reg <= `ETP_C_RESET;
      ext_en_reg <= '0;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        `ETP_OFF_CTRL_B: ctrl_b_reg <= bus_in.wdata;
        `ETP_OFF_CTRL_C: ctrl_c_reg <= bus_in.wdata;
        `ETP_OFF_EXT_EN: ext_en_reg <= bus_in.wdata[EXT_LINES-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset-cause register; hardware causes from cause_set_in
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rcause_reg <= `ETP_RC_RESET;
    end else begin
      if (bus_in.wr && bus_in.addr == `ETP_OFF_RCAUSE) begin
        // Watchdog and power-down bits are read-only
        // A cause arriving beside a software write is kept, not lost
        rcause_reg <= (bus_in.wdata & `ETP_RC_SW_MASK)
          | (rcause_reg & ~`ETP_RC_SW_MASK)
          | {2'b00, cause_set_in};
      end else if (|cause_set_in) begin
        rcause_reg[5:0] <= rcause_reg[5:0] | cause_set_in;
      end
      rcause_reg[`ETP_RC_UNUSED] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request steering to high and low level
  always_comb begin
    any_high = 1'b0;
    any_low  = 1'b0;
    for (int i = 0; i < EXT_LINES; i++) begin
      if (ext_flag_reg[i] && ext_en_reg[i]) begin
        // Priority ignored when levels are off
        if (!prio_en || ext_prio[i]) any_high = 1'b1;
        else any_low = 1'b1;
      end
    end
    if (ctrl_a_reg[`ETP_A_TMR_FLAG] && ctrl_a_reg[`ETP_A_TMR_EN]) begin
      if (!prio_en || ctrl_b_reg[`ETP_B_TMR_PRIO]) any_high = 1'b1;
      else any_low = 1'b1;
    end
    if (ctrl_a_reg[`ETP_A_PCH_FLAG] && ctrl_a_reg[`ETP_A_PCH_EN]) begin
      if (!prio_en || ctrl_b_reg[`ETP_B_PCH_PRIO]) any_high = 1'b1;
      else any_low = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep, wake and entry sequencing
  // Arm captured at sleep entry so enables set later cannot wake
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg    <= ETP_RUN;
      wake_arm_reg <= '0;
    end else begin
      case (state_reg)
        ETP_RUN: begin
          if (sleep_req_in) begin
            state_reg    <= ETP_SLEEP;
            wake_arm_reg <= ext_en_reg;
          end else if (ctrl_a_reg[`ETP_A_GIE] && (any_high || any_low)) begin
            state_reg <= ETP_ENTRY;
          end
        end
        ETP_SLEEP: begin
          if (|(ext_flag_reg & wake_arm_reg)) begin
            state_reg <= ctrl_a_reg[`ETP_A_GIE] ? ETP_ENTRY : ETP_RUN;
          end
        end
        ETP_ENTRY: begin
          if (entry_ack_in) state_reg <= ETP_RUN;
        end
        default: state_reg <= ETP_RUN;
      endcase
    end
  end

  // Return address stack push and fast-return shadow
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sp_reg     <= 5'h00;
      shadow_reg <= '0;
    end else if (state_reg == ETP_ENTRY && entry_ack_in) begin
      stack_mem[sp_reg] <= ctx_in.ret_pc;
      sp_reg            <= sp_reg + 5'h01;
      shadow_reg        <= ctx_in;
    end
  end

  assign stack_top_out = (sp_reg == 5'h00) ? 21'h00_0000
                                           : stack_mem[sp_reg - 5'h01];
  assign stack_ptr_out = sp_reg;
  assign shadow_out    = shadow_reg;

  ////////////////////////////////////////////////////////////////////////
  // Status, clear and enable for the single interrupt output
  assign stat_evt = {port_change, tmr_wrap, |ext_edge};
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stat_reg    <= 3'h0;
      stat_en_reg <= 3'h0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      stat_reg <= (stat_reg & ~((bus_in.wr && bus_in.addr == `ETP_OFF_IRQ_CLR)
                  ? bus_in.wdata[2:0] : 3'h0)) | stat_evt;
      if (bus_in.wr && bus_in.addr == `ETP_OFF_IRQ_EN) begin
        stat_en_reg <= bus_in.wdata[2:0];
      end
    end
  end
  assign irq_out = |(stat_reg & stat_en_reg);

  // Core signals
  always_comb begin
    core_out          = '0;
    core_out.irq_high = any_high;
    core_out.irq_low  = prio_en && any_low;
    core_out.wake     = state_reg == ETP_SLEEP && |(ext_flag_reg & wake_arm_reg);
    core_out.vector   = state_reg == ETP_ENTRY;
    core_out.resume   = core_out.wake && !ctrl_a_reg[`ETP_A_GIE];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        `ETP_OFF_RCAUSE:   rdata_out <= rcause_reg & 8'hBF;
        `ETP_OFF_CTRL_A:   rdata_out <= ctrl_a_reg;
        `ETP_OFF_CTRL_B:   rdata_out <= ctrl_b_reg;
        `ETP_OFF_CTRL_C:   rdata_out <= ctrl_c_reg;
        `ETP_OFF_EXT_FLAG: rdata_out <= {4'h0, ext_flag_reg};
        `ETP_OFF_EXT_EN:   rdata_out <= {4'h0, ext_en_reg};
        `ETP_OFF_IRQ_STAT: rdata_out <= {5'h00, stat_reg};
        `ETP_OFF_IRQ_EN:   rdata_out <= {5'h00, stat_en_reg};
        `ETP_OFF_TMR_LO:   rdata_out <= tmr_reg[7:0];
        `ETP_OFF_TMR_HI:   rdata_out <= tmr_reg[15:8];
        `ETP_OFF_TMR_CFG:  rdata_out <= {7'h00, tmr_16bit_reg};
        default:           rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pair_wrap;
    tmr_tick_in && tmr_16bit_reg && tmr_reg == 16'hFFFF;
  endsequence
  sequence s_byte_wrap;
    tmr_tick_in && !tmr_16bit_reg && tmr_reg[7:0] == 8'hFF;
  endsequence

  AST_BYTE_WRAP: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    s_byte_wrap |=> ctrl_a_reg[`ETP_A_TMR_FLAG])
    else $error("byte wrap lost");
  AST_PORT_CHANGE: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    port_pins_in != $past(port_pins_in) |=> ctrl_a_reg[`ETP_A_PCH_FLAG])
    else $error("port change missed");
  AST_ENTRY_PUSH: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    state_reg == ETP_ENTRY && entry_ack_in |=> shadow_reg == $past(ctx_in))
    else $error("context not shadowed at entry");

  AST_EDGE_SETS_FLAG: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) ext_edge[0] |=> ext_flag_reg[0])
    else $error("edge did not set line flag");
  AST_RISE_SEL: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ctrl_b_reg[4] |-> ext_edge[0] == $rose(ext_pins_in[0]))
    else $error("rising edge select wrong");
  AST_FALL_SEL: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !ctrl_b_reg[4] |-> ext_edge[0] == $fell(ext_pins_in[0]))
    else $error("falling edge select wrong");
  AST_LINE0_HIGH: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ext_flag_reg[0] && ext_en_reg[0] |-> core_out.irq_high)
    else $error("line zero not high priority");
  AST_NO_LOW_SINGLE: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) !prio_en |-> !core_out.irq_low
      && core_out.irq_high == (|(ext_flag_reg & ext_en_reg)
      || ctrl_a_reg[5] && ctrl_a_reg[2] || ctrl_a_reg[3] && ctrl_a_reg[0]))
    else $error("low level in single mode");
  AST_PAIR_WRAP: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    s_pair_wrap |=> ctrl_a_reg[`ETP_A_TMR_FLAG] && tmr_reg == 16'h0000)
    else $error("pair wrap lost");
  AST_BIT6_ZERO: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    $past(bus_in.rd) && $past(bus_in.addr) == 4'h0 |-> !rdata_out[6])
    else $error("unused bit read high");
  AST_FLAG_STICKY: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ctrl_a_reg[0] && !wr_a |=> ctrl_a_reg[0])
    else $error("port flag dropped");
  AST_WAKE_RESUME: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    core_out.wake && !ctrl_a_reg[7] |=> state_reg == ETP_RUN)
    else $error("no resume after wake");

endmodule

// file: sim/etp_core_model.sv
/*
  Behavioural model of the core side: takes the vector request and
  acknowledges entry after a set delay, offering a fixed context.
  Assumes one clock shared with the interrupt source block.
*/
`timescale 1ns/1ps
module etp_core_model
  import etp_pkg::*;
#(
  parameter int       ACK_DELAY = 3,
  parameter etp_ctx_t CTX       = '0
) (
  input  wire logic      clk_in,
  input  wire logic      reset_n_in,
  input  wire etp_core_t core_in,
  output logic           ack_out,
  output etp_ctx_t       ctx_out
);
  logic [3:0] wait_reg;

  ////////////////////////////////////////////////////////////////////////
  // Context presented at entry; handler-side saving is left to software
  assign ctx_out = CTX;

  // Acknowledge one cycle wide, only while vector is still asked for
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !core_in.vector || ack_out) begin
      wait_reg <= 4'h0;
      ack_out  <= 1'b0;
    end else if (wait_reg == ACK_DELAY[3:0]) begin
      ack_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// file: sim/ext_timer_port_irq_sources_tb.sv
/*
  Self-checking bench for the interrupt source block: register port,
  edge and change sources, timer wrap, priority steering, wake, entry.
  Assumes the register map and reset values of etp_regs.svh.
*/
`timescale 1ns/1ps
`include "etp_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module ext_timer_port_irq_sources_tb
  import etp_pkg::*;
;
  localparam etp_ctx_t CTX = '{21'h1_2345, 8'hA5, 8'h3C, 4'h9};
  logic        clk_in;
  logic        reset_n_in;
  etp_bus_t    bus;
  logic [7:0]  rdata_out;
  logic [3:0]  ext_pins;
  logic [7:4]  port_pins;
  logic        tmr_tick;
  logic        sleep_req;
  logic        entry_ack;
  etp_ctx_t    ctx;
  logic [5:0]  cause_set;
  etp_core_t   core_out;
  etp_ctx_t    shadow_out;
  logic [20:0] stack_top_out;
  logic [4:0]  stack_ptr_out;
  logic        irq_out;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  etp_irq_sources etp_irq_sources_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus),
    .rdata_out(rdata_out), .ext_pins_in(ext_pins),
    .port_pins_in(port_pins), .tmr_tick_in(tmr_tick),
    .sleep_req_in(sleep_req), .entry_ack_in(entry_ack), .ctx_in(ctx),
    .cause_set_in(cause_set), .core_out(core_out),
    .shadow_out(shadow_out), .stack_top_out(stack_top_out),
    .stack_ptr_out(stack_ptr_out), .irq_out(irq_out));

  etp_core_model #(.ACK_DELAY(3), .CTX(CTX)) etp_core_model_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .core_in(core_out),
    .ack_out(entry_ack), .ctx_out(ctx));

  ////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the whole run
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 `CHK(rdata_out, e)
    @(posedge clk_in);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse_tick();
    @(posedge clk_in);
    tmr_tick <= 1'b1;
    @(posedge clk_in);
    tmr_tick <= 1'b0;
    idle(3);
  endtask
  task automatic sleep_now();
    @(posedge clk_in);
    sleep_req <= 1'b1;
    @(posedge clk_in);
    sleep_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_cause();
    chk_rd(`ETP_OFF_RCAUSE, 8'h3C);
    chk_rd(`ETP_OFF_CTRL_B, 8'hF7);
    chk_rd(`ETP_OFF_CTRL_C, 8'hC0);
    chk_rd(4'hC, 8'h00);
    wr(`ETP_OFF_RCAUSE, 8'hFF);
    chk_rd(`ETP_OFF_RCAUSE, 8'hBF);
    wr(`ETP_OFF_RCAUSE, 8'h00);
    chk_rd(`ETP_OFF_RCAUSE, 8'h0C);
    @(posedge clk_in);
    cause_set <= 6'h01;
    @(posedge clk_in);
    cause_set <= 6'h00;
    chk_rd(`ETP_OFF_RCAUSE, 8'h0D);
  endtask

  task automatic t_edges();
    for (int i = 0; i < 4; i++) begin
      ext_pins[i] <= 1'b1;
      idle(4);
      chk_rd(`ETP_OFF_EXT_FLAG, 8'((2 << i) - 1));
    end
    wr(`ETP_OFF_CTRL_B, 8'h07);
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ext_pins[i] <= 1'b0;
      idle(4);
      chk_rd(`ETP_OFF_EXT_FLAG, 8'((2 << i) - 1));
    end
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
    ext_pins <= 4'hF;
    idle(4);
    chk_rd(`ETP_OFF_EXT_FLAG, 8'h00);
    wr(`ETP_OFF_CTRL_B, 8'hF7);
  endtask

  task automatic t_irq_out();
    wr(`ETP_OFF_IRQ_EN, 8'h00);
    wr(`ETP_OFF_IRQ_CLR, 8'h07);
    ext_pins <= 4'h0;
    idle(4);
    ext_pins[2] <= 1'b1;
    idle(4);
    chk_rd(`ETP_OFF_IRQ_STAT, 8'h01);
    `CHK(irq_out, 1'b0)
    wr(`ETP_OFF_IRQ_EN, 8'h01);
    idle(1);
    `CHK(irq_out, 1'b1)
    wr(`ETP_OFF_IRQ_CLR, 8'h01);
    idle(1);
    `CHK(irq_out, 1'b0)
    chk_rd(`ETP_OFF_IRQ_STAT, 8'h00);
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
  endtask

  task automatic t_priority();
    wr(`ETP_OFF_EXT_EN, 8'h0F);
    wr(`ETP_OFF_CTRL_C, 8'h00);
    wr(`ETP_OFF_EXT_FLAG, 8'h02);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b10)
    wr(`ETP_OFF_RCAUSE, 8'h80);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b01)
    wr(`ETP_OFF_CTRL_C, 8'h40);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b10)
    wr(`ETP_OFF_EXT_FLAG, 8'h01);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b10)
    wr(`ETP_OFF_CTRL_B, 8'hF5);
    wr(`ETP_OFF_EXT_FLAG, 8'h08);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b01)
    wr(`ETP_OFF_RCAUSE, 8'h00);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b10)
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
    wr(`ETP_OFF_EXT_EN, 8'h00);
    wr(`ETP_OFF_CTRL_B, 8'hF7);
    wr(`ETP_OFF_CTRL_C, 8'hC0);
  endtask

  task automatic t_timer();
    wr(`ETP_OFF_IRQ_CLR, 8'h07);
    wr(`ETP_OFF_TMR_LO, 8'hFE);
    pulse_tick();
    chk_rd(`ETP_OFF_CTRL_A, 8'h00);
    pulse_tick();
    chk_rd(`ETP_OFF_CTRL_A, 8'h04);
    chk_rd(`ETP_OFF_TMR_LO, 8'h00);
    wr(`ETP_OFF_CTRL_A, 8'h00);
    wr(`ETP_OFF_TMR_CFG, 8'h01);
    wr(`ETP_OFF_TMR_HI, 8'h00);
    wr(`ETP_OFF_TMR_LO, 8'hFF);
    pulse_tick();
    chk_rd(`ETP_OFF_CTRL_A, 8'h00);
    chk_rd(`ETP_OFF_TMR_HI, 8'h01);
    wr(`ETP_OFF_TMR_HI, 8'hFF);
    wr(`ETP_OFF_TMR_LO, 8'hFF);
    pulse_tick();
    chk_rd(`ETP_OFF_CTRL_A, 8'h04);
    wr(`ETP_OFF_CTRL_A, 8'h24);
    chk_rd(`ETP_OFF_CTRL_A, 8'h24);
    `CHK(core_out.irq_high, 1'b1)
    wr(`ETP_OFF_RCAUSE, 8'h80);
    wr(`ETP_OFF_CTRL_B, 8'hF3);
    idle(1);
    `CHK({core_out.irq_high, core_out.irq_low}, 2'b01)
    wr(`ETP_OFF_RCAUSE, 8'h00);
    wr(`ETP_OFF_CTRL_B, 8'hF7);
    wr(`ETP_OFF_CTRL_A, 8'h04);
    idle(1);
    `CHK(core_out.irq_high, 1'b0)
    wr(`ETP_OFF_CTRL_A, 8'h00);
    wr(`ETP_OFF_IRQ_CLR, 8'h07);
    port_pins <= 4'h5;
    idle(4);
    chk_rd(`ETP_OFF_CTRL_A, 8'h01);
    chk_rd(`ETP_OFF_IRQ_STAT, 8'h04);
    wr(`ETP_OFF_CTRL_A, 8'h09);
    idle(1);
    `CHK(core_out.irq_high, 1'b1)
    wr(`ETP_OFF_CTRL_A, 8'h00);
    wr(`ETP_OFF_IRQ_CLR, 8'h07);
  endtask

  task automatic t_wake();
    int n;
    ext_pins <= 4'h0;
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
    wr(`ETP_OFF_EXT_EN, 8'h01);
    sleep_now();
    ext_pins[0] <= 1'b1;
    n = 0;
    while (core_out.resume !== 1'b1 && n < 10) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(core_out.resume, 1'b1)
    `CHK(core_out.wake, 1'b1)
    `CHK(core_out.vector, 1'b0)
    ext_pins <= 4'h0;
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
    sleep_now();
    wr(`ETP_OFF_CTRL_A, 8'h80);
    ext_pins[0] <= 1'b1;
    n = 0;
    while (stack_ptr_out === 5'd0 && n < 30) begin
      @(posedge clk_in);
      n++;
    end
    #1 `CHK(stack_ptr_out, 5'd1)
    `CHK(stack_top_out, CTX.ret_pc)
    `CHK(shadow_out, CTX)
    wr(`ETP_OFF_CTRL_A, 8'h00);
    wr(`ETP_OFF_EXT_FLAG, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: everything driven from time zero, reset 20 cycles
  initial begin
    reset_n_in = 1'b0;
    bus        = '0;
    ext_pins   = 4'h0;
    port_pins  = 4'h0;
    tmr_tick   = 1'b0;
    sleep_req  = 1'b0;
    cause_set  = 6'h00;
    idle(20);
    reset_n_in <= 1'b1;
    idle(2);
    t_reset_cause();
    t_edges();
    t_irq_out();
    t_priority();
    t_timer();
    t_wake();
    idle(5);
    close_out();
  end
endmodule
